// file: spi_master_xfer.sv
// Purpose: usart in master spi mode, data path, flags and irq requests
// Assumes: apb slave with zero wait states, single clock
// Notes: port muxing lives outside; the override outputs steer it
//
// Summary of operation
// - master mode runs only with transmitter enabled; it then owns the output pin
// - receiver is optional; when enabled it owns the input pin
// - the clock pin is the transfer clock in either configuration
// - each accepted data write starts one full duplex frame
// - written byte waits in buffer, loaded when shifter is free
// - on receive overflow the newest byte is dropped, older kept
// - framing, overrun and parity flags always read zero
// - receive complete is high while unread data exists, cleared on disable
// - transmit complete sets after frame with empty buffer, clears on ack or one
// - buffer empty flag is high when buffer can take a byte, set at reset
// - each irq needs its enable, global enable and its flag
// - clearing receiver enable flushes the receive buffer
// - receiver alone performs no transfers
// - transmitter disable waits until shifter and buffer are empty
// - transmit double buffered, receive buffer two deep
// - master only, no collision flag, no double speed, no select input
// - output pin is mosi, input pin miso, clock pin sck
// - polarity, phase and order behave like spi cpol, cpha, dord
// - polarity and phase pick spi modes 0 to 3, opposite edges
// - eight bit frames, msb or lsb first, same for both directions
// - sck rate is clk over twice (divisor plus one)
// - master spi only when both mode bits are one
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module spi_master_xfer (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic global_irq_enable,
   input wire logic tx_complete_irq_ack,
   output logic rx_complete_irq,
   output logic tx_complete_irq,
   output logic buffer_empty_irq,
   output logic serial_out_pin,
   output logic serial_out_override,
   input wire logic serial_in_pin,
   output logic serial_in_override,
   output logic transfer_clock_pin
);
   spi_master_pkg::xfer_state_t state_r;
   logic [7:0] ctl_b_r;
   logic [7:0] ctl_c_r;
   logic [11:0] baud_divisor_r;
   logic [7:0] tx_buf_r;
   logic tx_buf_full_r;
   logic [7:0] tx_shift_r;
   logic [7:0] rx_shift_r;
   logic [3:0] edge_cnt_r;
   logic sck_phase_r;
   logic [7:0] rx_mem_r [0:1];
   logic rd_ptr_r;
   logic [1:0] rx_count_r;
   logic tx_complete_flag_r;
   logic sin_meta_r;
   logic sin_sync_r;
   logic rd_valid_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic rx_irq_r;
   logic tx_irq_r;
   logic udre_irq_r;
   logic sout_r;
   logic sout_ovr_r;
   logic sin_ovr_r;
   logic sck_r;

   function automatic logic first_bit(input logic [7:0] v, input logic lsb);
      first_bit = lsb ? v[0] : v[7];
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                           input logic lsb);
      shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
   endfunction

   // control decode
   wire rx_enable = ctl_b_r[spi_master_pkg::RXEN_BIT];
   wire tx_enable = ctl_b_r[spi_master_pkg::TXEN_BIT];
   wire bit_order_select = ctl_c_r[spi_master_pkg::ORDER_BIT];
   wire clock_phase_select = ctl_c_r[spi_master_pkg::CPHA_BIT];
   wire clock_polarity_select = ctl_c_r[spi_master_pkg::CPOL_BIT];
   wire [1:0] mode_select_bits = {ctl_c_r[spi_master_pkg::MODE_HI_BIT],
                                  ctl_c_r[spi_master_pkg::MODE_LO_BIT]};
   wire master_spi_mode = (mode_select_bits == spi_master_pkg::MODE_MASTER_SPI);

   // apb decode
   wire setup_ph = psel && !penable;
   wire access_ph = psel && penable && pready_r;
   wire wr_acc = access_ph && pwrite;
   wire rd_acc = access_ph && !pwrite;
   wire hit_data = (paddr == spi_master_pkg::ADDR_DATA);
   wire hit_stat = (paddr == spi_master_pkg::ADDR_STATUS_A);
   wire hit_ctlb = (paddr == spi_master_pkg::ADDR_CONTROL_B);
   wire hit_ctlc = (paddr == spi_master_pkg::ADDR_CONTROL_C);
   wire hit_baud = (paddr == spi_master_pkg::ADDR_BAUD);
   wire hit_any = hit_data || hit_stat || hit_ctlb || hit_ctlc || hit_baud;

   // flags
   wire rx_complete_flag = (rx_count_r != 2'h0);
   wire tx_buffer_empty_flag = !tx_buf_full_r;
   // error flags sit at bits 4..2 and are tied low in this mode
   wire [7:0] status_a = {rx_complete_flag, tx_complete_flag_r, tx_buffer_empty_flag,
                          5'h00};

   wire [7:0] rx_head = rx_mem_r[rd_ptr_r];
   wire [31:0] rd_mux = hit_data ? {24'h000000, rx_head} :
                        hit_stat ? {24'h000000, status_a} :
                        hit_ctlb ? {24'h000000, ctl_b_r} :
                        hit_ctlc ? {24'h000000, ctl_c_r} :
                        hit_baud ? {20'h00000, baud_divisor_r} : 32'h00000000;

   // writes to data are dropped when buffer is full or transmitter is off
   wire data_wr = wr_acc && hit_data && tx_enable && !tx_buf_full_r;
   wire data_rd = rd_acc && hit_data && rd_valid_r;

   // transfer engine
   wire tick;
   wire shifting = (state_r == spi_master_pkg::ST_SHIFT);
   wire lead_edge = !edge_cnt_r[0];
   wire sample_edge = tick && shifting && (lead_edge != clock_phase_select);
   wire setup_edge = tick && shifting && (lead_edge == clock_phase_select) &&
                     !(clock_phase_select && edge_cnt_r == 4'h0);
   wire frame_done = tick && shifting && (edge_cnt_r == spi_master_pkg::LAST_EDGE);
   // a queued byte finishes even after the transmitter is disabled
   wire can_load = master_spi_mode && tx_buf_full_r;
   wire load_now = can_load && (!shifting || frame_done);
   wire [7:0] rx_byte = shift_in(rx_shift_r, sin_sync_r, bit_order_select);
   // phase 0 took its last bit one edge earlier, so the shifter is already whole
   wire [7:0] rx_frame_byte = clock_phase_select ? rx_byte : rx_shift_r;
   wire rx_push = frame_done && rx_enable &&
                  (rx_count_r != spi_master_pkg::RX_DEPTH || data_rd);
   wire wr_idx = rd_ptr_r ^ rx_count_r[0];
   wire tx_active = tx_enable || tx_buf_full_r || shifting;
   wire sck_phase_nxt = tick && shifting ? !sck_phase_r : sck_phase_r;
   wire txc_clear = (wr_acc && hit_stat && pwdata[spi_master_pkg::TXC_BIT]) ||
                    tx_complete_irq_ack;
   wire txc_set = frame_done && !tx_buf_full_r;

   spi_baud_tick u_baud (
      .clk(clk),
      .arst_n(arst_n),
      .run(shifting),
      .divisor(baud_divisor_r),
      .tick(tick)
   );

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign rx_complete_irq = rx_irq_r;
   assign tx_complete_irq = tx_irq_r;
   assign buffer_empty_irq = udre_irq_r;
   assign serial_out_pin = sout_r;
   assign serial_out_override = sout_ovr_r;
   assign serial_in_override = sin_ovr_r;
   assign transfer_clock_pin = sck_r;

   // apb answer: data captured in setup, one access cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         rd_valid_r <= 1'b0;
      end else begin
         pready_r <= setup_ph;
         if (setup_ph) begin
            prdata_r <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_r <= !hit_any;
            // only pop a byte that was really returned
            rd_valid_r <= rx_complete_flag;
         end
      end
   end

   // control registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl_b_r <= spi_master_pkg::CONTROL_B_RST;
         ctl_c_r <= spi_master_pkg::CONTROL_C_RST;
         baud_divisor_r <= spi_master_pkg::BAUD_RST;
      end else if (wr_acc) begin
         if (hit_ctlb) begin
            ctl_b_r <= {pwdata[7:3], 3'h0};
         end else if (hit_ctlc) begin
            ctl_c_r <= {pwdata[7:6], 3'h0, pwdata[2:0]};
         end else if (hit_baud) begin
            baud_divisor_r <= pwdata[11:0];
         end
      end
   end

   // transmit buffer and transmit complete flag
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_buf_r <= 8'h00;
         tx_buf_full_r <= 1'b0;
         tx_complete_flag_r <= 1'b0;
      end else begin
         if (data_wr) begin
            tx_buf_r <= pwdata[7:0];
            tx_buf_full_r <= 1'b1;
         end else if (load_now) begin
            tx_buf_full_r <= 1'b0;
         end
         // a set in the clearing cycle wins
         if (txc_set) begin
            tx_complete_flag_r <= 1'b1;
         end else if (txc_clear) begin
            tx_complete_flag_r <= 1'b0;
         end
      end
   end

   // frame sequencer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= spi_master_pkg::ST_IDLE;
         tx_shift_r <= 8'h00;
         rx_shift_r <= 8'h00;
         edge_cnt_r <= 4'h0;
         sck_phase_r <= 1'b0;
      end else begin
         sck_phase_r <= sck_phase_nxt;
         if (load_now) begin
            state_r <= spi_master_pkg::ST_SHIFT;
            tx_shift_r <= tx_buf_r;
            edge_cnt_r <= 4'h0;
         end else if (frame_done) begin
            state_r <= spi_master_pkg::ST_IDLE;
         end else if (tick && shifting) begin
            edge_cnt_r <= edge_cnt_r + 4'h1;
            if (setup_edge) begin
               tx_shift_r <= bit_order_select ? {1'b0, tx_shift_r[7:1]} :
                                                {tx_shift_r[6:0], 1'b0};
            end
         end
         if (sample_edge) begin
            rx_shift_r <= rx_byte;
         end
      end
   end

   // receive buffer, two deep
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_mem_r[0] <= 8'h00;
         rx_mem_r[1] <= 8'h00;
         rd_ptr_r <= 1'b0;
         rx_count_r <= 2'h0;
      end else if (!rx_enable) begin
         rx_count_r <= 2'h0;
      end else begin
         if (rx_push) begin
            rx_mem_r[wr_idx] <= rx_frame_byte;
         end
         if (data_rd) begin
            rd_ptr_r <= !rd_ptr_r;
         end
         if (rx_push && !data_rd) begin
            rx_count_r <= rx_count_r + 2'h1;
         end else if (data_rd && !rx_push) begin
            rx_count_r <= rx_count_r - 2'h1;
         end
      end
   end

   // pins and interrupt requests
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sin_meta_r <= 1'b1;
         sin_sync_r <= 1'b1;
         sout_r <= 1'b1;
         sout_ovr_r <= 1'b0;
         sin_ovr_r <= 1'b0;
         sck_r <= 1'b0;
         rx_irq_r <= 1'b0;
         tx_irq_r <= 1'b0;
         udre_irq_r <= 1'b0;
      end else begin
         sin_meta_r <= serial_in_pin;
         sin_sync_r <= sin_meta_r;
         sout_r <= shifting ? first_bit(tx_shift_r, bit_order_select) : 1'b1;
         sout_ovr_r <= tx_active;
         sin_ovr_r <= rx_enable;
         sck_r <= clock_polarity_select ^ sck_phase_nxt;
         rx_irq_r <= ctl_b_r[spi_master_pkg::RXCIE_BIT] && global_irq_enable &&
                     rx_complete_flag;
         tx_irq_r <= ctl_b_r[spi_master_pkg::TXCIE_BIT] && global_irq_enable &&
                     tx_complete_flag_r;
         udre_irq_r <= ctl_b_r[spi_master_pkg::EMPTY_IE_BIT] && global_irq_enable &&
                       tx_buffer_empty_flag;
      end
   end

   sequence frame_end_s;
      frame_done && rx_enable && rx_count_r == spi_master_pkg::RX_DEPTH && !data_rd;
   endsequence

   flush_rx_a: assert property (@(posedge clk) disable iff (!arst_n)
      !rx_enable |=> rx_count_r == 2'h0)
      else $error("receive buffer not flushed");
   sck_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
      !shifting && !$past(shifting) |-> sck_r == $past(clock_polarity_select))
      else $error("serial clock not at idle level");
   rx_only_a: assert property (@(posedge clk) disable iff (!arst_n)
      !shifting && !tx_buf_full_r && !tx_enable |=> !shifting)
      else $error("transfer without transmitter");
   txc_set_a: assert property (@(posedge clk) disable iff (!arst_n)
      txc_set |=> tx_complete_flag_r)
      else $error("transmit complete not set");
   udre_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
      data_wr |=> !tx_buffer_empty_flag ##1 1)
      else $error("buffer empty flag wrong after write");
   overflow_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
      frame_end_s |=> rx_count_r == spi_master_pkg::RX_DEPTH &&
                      $stable(rx_mem_r[0]) && $stable(rx_mem_r[1]))
      else $error("older byte overwritten on overflow");
   sck_toggle_a: assert property (@(posedge clk) disable iff (!arst_n)
      tick && shifting |=> sck_r != $past(sck_r))
      else $error("serial clock missed an edge");
   irq_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
      !global_irq_enable |=> !rx_irq_r && !tx_irq_r && !udre_irq_r)
      else $error("irq without global enable");
   out_ovr_a: assert property (@(posedge clk) disable iff (!arst_n)
      tx_enable |=> sout_ovr_r)
      else $error("output pin not overridden");
   no_gap_a: assert property (@(posedge clk) disable iff (!arst_n)
      frame_done && can_load |=> shifting && edge_cnt_r == 4'h0)
      else $error("gap between queued frames");
   err_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
      setup_ph && !pwrite && hit_stat |=> prdata_r[4:0] == 5'h00)
      else $error("error flags not zero");
endmodule

// file: spi_master_pkg.sv
// Purpose: shared constants of the usart spi master transfer block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: narrow registers sit in the low bits (baud in 11:0), upper bits read zero
package spi_master_pkg;
   // register byte addresses
   localparam logic [11:0] ADDR_DATA = 12'h000;
   localparam logic [11:0] ADDR_STATUS_A = 12'h004;
   localparam logic [11:0] ADDR_CONTROL_B = 12'h008;
   localparam logic [11:0] ADDR_CONTROL_C = 12'h00c;
   localparam logic [11:0] ADDR_BAUD = 12'h010;
   // spi_status_a fields
   localparam int RXC_BIT = 7;
   localparam int TXC_BIT = 6;
   localparam int UDRE_BIT = 5;
   // spi_control_b fields
   localparam int RXCIE_BIT = 7;
   localparam int TXCIE_BIT = 6;
   localparam int EMPTY_IE_BIT = 5;
   localparam int RXEN_BIT = 4;
   localparam int TXEN_BIT = 3;
   // spi_control_c fields
   localparam int MODE_HI_BIT = 7;
   localparam int MODE_LO_BIT = 6;
   localparam int ORDER_BIT = 2;
   localparam int CPHA_BIT = 1;
   localparam int CPOL_BIT = 0;
   localparam logic [1:0] MODE_MASTER_SPI = 2'h3;
   // reset values
   localparam logic [7:0] CONTROL_B_RST = 8'h00;
   localparam logic [7:0] CONTROL_C_RST = 8'h00;
   localparam logic [11:0] BAUD_RST = 12'h000;
   // frame shape
   localparam int FRAME_BITS = 8;
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam logic [1:0] RX_DEPTH = 2'h2;
   typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_t;
endpackage

// file: spi_baud_tick.sv
// Purpose: half-period tick for the serial clock
// Assumes: divisor stable while a frame runs
// Notes: one tick every divisor+1 cycles, so sck = clk / (2*(divisor+1))
`timescale 1ns/10ps
module spi_baud_tick (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic run,
   input wire logic [11:0] divisor,
   output logic tick
);
   logic [11:0] cnt_r;
   logic tick_r;

   assign tick = tick_r;

   // restarting on idle keeps the first half period full length
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 12'h000;
         tick_r <= 1'b0;
      end else if (!run) begin
         cnt_r <= divisor;
         tick_r <= 1'b0;
      end else if (cnt_r == 12'h000) begin
         cnt_r <= divisor;
         tick_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r - 12'h001;
         tick_r <= 1'b0;
      end
   end
endmodule

// file: spi_slave_model.sv
// Purpose: behavioural spi slave facing the master block
// Assumes: restart is pulsed whenever the clock idle level changes
// Notes: answers reply plus its frame count, so each frame differs
`timescale 1ns/10ps
module spi_slave_model (
   input wire logic sck,
   input wire logic mosi,
   input wire logic cpha,
   input wire logic lsb,
   input wire logic restart,
   input wire logic [7:0] reply,
   output logic miso,
   output logic [7:0] got,
   output logic [7:0] frames
);
   int n = 0;
   logic [7:0] si = 8'h00;
   logic [7:0] so = 8'h00;
   initial begin
      frames = 8'h00;
      got = 8'h00;
      miso = 1'b1;
   end
   always @(posedge restart or reply or lsb) begin
      n = 0;
      so = reply + frames;
      miso = lsb ? so[0] : so[7];
   end
   always @(sck) begin
      n = n + 1;
      if ((n % 2 == 1) == (cpha == 1'b0)) begin
         si = lsb ? {mosi, si[7:1]} : {si[6:0], mosi};
      end else begin
         // first setup edge of phase 1 shows the already loaded bit
         if (n > 1 || cpha == 1'b0) begin
            so = lsb ? so >> 1 : so << 1;
         end
         miso = lsb ? so[0] : so[7];
      end
      if (n == 16) begin
         got = si;
         frames = frames + 8'h01;
         n = 0;
         so = reply + frames;
         // on a sample edge miso must hold, so the new bit waits
         if (cpha == 1'b0) begin
            miso = lsb ? so[0] : so[7];
         end
      end
   end
endmodule

// file: test_usart_master_spi_transfer.sv
// Purpose: self-checking bench for the spi master transfer block
// Assumes: divisor 3, so each sck half period is four clocks
// Notes: the slave answers 8'hc3 plus its frame count
`timescale 1ns/10ps
module test_usart_master_spi_transfer;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic gie = 1'b0;
   logic ack = 1'b0;
   logic cpha = 1'b0;
   logic lsb = 1'b0;
   logic restart = 1'b0;
   logic [31:0] prdata, q;
   logic pready, pslverr, serr, rx_irq, tx_irq, empty_irq;
   logic mosi, out_ovr, miso, in_ovr, sck;
   logic sck_q = 1'b0;
   logic [7:0] got, frames;
   int err_total = 0;
   int compares = 0;
   int cyc = 0, last = 0, per = 0, edges = 0;
   spi_master_xfer u_spi_master_xfer (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .global_irq_enable(gie),
      .tx_complete_irq_ack(ack), .rx_complete_irq(rx_irq), .tx_complete_irq(tx_irq),
      .buffer_empty_irq(empty_irq), .serial_out_pin(mosi), .serial_out_override(out_ovr),
      .serial_in_pin(miso), .serial_in_override(in_ovr), .transfer_clock_pin(sck));
   spi_slave_model u_spi_slave_model (.sck(sck), .mosi(mosi), .cpha(cpha), .lsb(lsb),
      .restart(restart), .reply(8'hc3), .miso(miso), .got(got), .frames(frames));
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (sck !== sck_q) begin
         per = cyc - last;
         last = cyc;
         edges++;
      end
      sck_q = sck;
   end
   task automatic test_done;
      $display("compares=%0d mismatches=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one idle cycle after each transfer keeps drivers single per step
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      // the answer stands for one cycle only
      if (pready !== 1'b0) chk(32'h1, 32'h0);
   endtask
   task automatic wait_bit(input int b, input logic v);
      int n;
      n = 0;
      do begin
         apb(1'b0, spi_master_pkg::ADDR_STATUS_A, 8'h00);
         n++;
      end while (q[b] !== v && n < 400);
      chk({31'h0, q[b]}, {31'h0, v});
   endtask
   task automatic cfg(input logic [2:0] m);
      apb(1'b1, spi_master_pkg::ADDR_CONTROL_C, {2'h3, 3'h0, m});
      lsb <= m[2];
      cpha <= m[1];
      repeat (3) @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
   endtask
   task automatic t_reset;
      apb(1'b0, spi_master_pkg::ADDR_STATUS_A, 8'h00);
      chk(q, 32'h20);
      apb(1'b0, spi_master_pkg::ADDR_CONTROL_B, 8'h00);
      chk(q, 32'h0);
      apb(1'b0, 12'h0ff, 8'h00);
      chk({31'h0, serr}, 32'h1);
      chk(q, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_modes;
      logic [7:0] k, d;
      apb(1'b1, spi_master_pkg::ADDR_CONTROL_B, 8'h18);
      for (int i = 0; i < 8; i++) begin
         cfg(i[2:0]);
         k = frames;
         d = 8'h5a ^ i[7:0];
         apb(1'b1, spi_master_pkg::ADDR_DATA, d);
         wait_bit(spi_master_pkg::RXC_BIT, 1'b1);
         apb(1'b0, spi_master_pkg::ADDR_DATA, 8'h00);
         chk(q, {24'h0, 8'hc3 + k});
         chk({24'h0, got}, {24'h0, d});
         chk({31'h0, sck}, {31'h0, i[0]});
         chk(per, 4);
      end
      $display("test modes done");
   endtask
   task automatic t_overflow;
      logic [7:0] k;
      cfg(3'h0);
      apb(1'b1, spi_master_pkg::ADDR_STATUS_A, 8'h40);
      k = frames;
      for (int i = 0; i < 3; i++) begin
         wait_bit(spi_master_pkg::UDRE_BIT, 1'b1);
         apb(1'b1, spi_master_pkg::ADDR_DATA, 8'h10 + i[7:0]);
      end
      wait_bit(spi_master_pkg::TXC_BIT, 1'b1);
      chk({24'h0, frames - k}, 32'h3);
      apb(1'b0, spi_master_pkg::ADDR_DATA, 8'h00);
      chk(q, {24'h0, 8'hc3 + k});
      apb(1'b0, spi_master_pkg::ADDR_DATA, 8'h00);
      chk(q, {24'h0, 8'hc4 + k});
      apb(1'b0, spi_master_pkg::ADDR_STATUS_A, 8'h00);
      chk(q, 32'h60);
      apb(1'b1, spi_master_pkg::ADDR_STATUS_A, 8'h40);
      apb(1'b0, spi_master_pkg::ADDR_STATUS_A, 8'h00);
      chk(q, 32'h20);
      $display("test overflow done");
   endtask
   task automatic t_irq;
      logic [7:0] k;
      apb(1'b1, spi_master_pkg::ADDR_CONTROL_B, 8'hf8);
      gie <= 1'b1;
      repeat (3) @(posedge clk);
      chk({29'h0, rx_irq, tx_irq, empty_irq}, 32'h1);
      k = frames;
      apb(1'b1, spi_master_pkg::ADDR_DATA, 8'h77);
      wait_bit(spi_master_pkg::TXC_BIT, 1'b1);
      repeat (2) @(posedge clk);
      chk({29'h0, rx_irq, tx_irq, empty_irq}, 32'h7);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      repeat (3) @(posedge clk);
      chk({29'h0, rx_irq, tx_irq, empty_irq}, 32'h5);
      gie <= 1'b0;
      repeat (3) @(posedge clk);
      chk({29'h0, rx_irq, tx_irq, empty_irq}, 32'h0);
      apb(1'b0, spi_master_pkg::ADDR_DATA, 8'h00);
      chk(q, {24'h0, 8'hc3 + k});
      $display("test irq done");
   endtask
   task automatic t_rx_only;
      int e;
      logic [7:0] k;
      apb(1'b1, spi_master_pkg::ADDR_CONTROL_B, 8'h10);
      repeat (3) @(posedge clk);
      chk({30'h0, out_ovr, in_ovr}, 32'h1);
      e = edges;
      apb(1'b1, spi_master_pkg::ADDR_DATA, 8'h55);
      repeat (200) @(posedge clk);
      chk(edges - e, 0);
      chk({31'h0, out_ovr}, 32'h0);
      // a byte written outside master spi mode must wait in the buffer
      apb(1'b1, spi_master_pkg::ADDR_CONTROL_B, 8'h18);
      apb(1'b1, spi_master_pkg::ADDR_CONTROL_C, 8'h00);
      k = frames;
      apb(1'b1, spi_master_pkg::ADDR_DATA, 8'h66);
      repeat (200) @(posedge clk);
      chk(edges - e, 0);
      apb(1'b0, spi_master_pkg::ADDR_STATUS_A, 8'h00);
      chk(q, 32'h0);
      cfg(3'h0);
      wait_bit(spi_master_pkg::RXC_BIT, 1'b1);
      apb(1'b0, spi_master_pkg::ADDR_DATA, 8'h00);
      chk(q, {24'h0, 8'hc3 + k});
      $display("test rx only done");
   endtask
   task automatic t_tx_off;
      apb(1'b1, spi_master_pkg::ADDR_CONTROL_B, 8'h18);
      apb(1'b1, spi_master_pkg::ADDR_DATA, 8'h21);
      apb(1'b1, spi_master_pkg::ADDR_CONTROL_B, 8'h10);
      chk({31'h0, out_ovr}, 32'h1);
      wait_bit(spi_master_pkg::RXC_BIT, 1'b1);
      repeat (3) @(posedge clk);
      chk({31'h0, out_ovr}, 32'h0);
      apb(1'b1, spi_master_pkg::ADDR_CONTROL_B, 8'h00);
      apb(1'b0, spi_master_pkg::ADDR_STATUS_A, 8'h00);
      chk(q, 32'h60);
      chk({31'h0, in_ovr}, 32'h0);
      $display("test tx disable done");
   endtask
   initial begin
      #200000;
      err_total++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      apb(1'b1, spi_master_pkg::ADDR_BAUD, 8'h03);
      t_modes();
      t_overflow();
      t_irq();
      t_rx_only();
      t_tx_off();
      test_done();
   end
endmodule
